// >>> sesm_top.sv
module sesm_top (
   input wire logic clock, // 20 MHz system clock
   input wire logic resetn, // synchronous, active low
   input wire sesm_pkg::sesm_bus_t bus, // register port request
   input wire logic enable_input_level, // enable pin, asynchronous
   input wire logic signed [31:0] measured_velocity, // feedback speed
   input wire logic signed [31:0] measured_position, // feedback position
   output logic [31:0] rdata, // read data, cycle after read strobe
   output logic drive_enable, // power stage enabled
   output logic motion_enable, // motor movement permitted
   output logic signed [31:0] demanded_speed, // speed set-point
   output logic signed [31:0] demanded_position // position set-point
);

   // ---------------------------------------------------------------
   // enable pin synchroniser
   // ---------------------------------------------------------------
   logic en_meta_reg, en_sync_reg;

   // two stages; only the second one is read by logic
   always_ff @(posedge clock) begin
      if (!resetn) begin
         en_meta_reg <= 1'b0;
         en_sync_reg <= 1'b0;
      end else begin
         en_meta_reg <= enable_input_level;
         en_sync_reg <= en_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   logic [15:0] cmd_reg, cmd_next;
   logic [7:0] mode_sel_reg, mode_sel_next;
   logic [7:0] mode_act_reg, mode_act_next;
   logic [1:0] sw_opt_reg, sw_opt_next;
   logic [1:0] estop_reg, estop_next;
   logic [31:0] decel_reg, decel_next;
   logic signed [31:0] target_reg, target_next;
   logic [1:0] fly_stat_reg, fly_stat_next;
   sesm_pkg::sesm_state_t st_reg, st_next;
   logic mode_ok, fly_ok, act_rt, fly_target;

   // a mode change is blocked in operation-enable while bit 4 is set
   always_comb begin
      mode_ok = (st_reg != sesm_pkg::ST_OP_ENABLE) ||
                !cmd_reg[sesm_pkg::CW_NEW_SETPOINT];
      act_rt = (mode_act_reg >= sesm_pkg::MODE_RT_LO) &&
               (mode_act_reg <= sesm_pkg::MODE_RT_HI);
      fly_target = (bus.wdata[7:0] == sesm_pkg::MODE_PROF_POS) ||
                   (bus.wdata[7:0] == sesm_pkg::MODE_HOMING) ||
                   (bus.wdata[7:0] == sesm_pkg::MODE_GEAR) ||
                   (bus.wdata[7:0] == sesm_pkg::MODE_PROF_VEL_C);
      // real-time modes are refused here: the process-data check is not ours
      fly_ok = (st_reg == sesm_pkg::ST_OP_ENABLE) && fly_target && !act_rt;
   end

   // register writes; address decode as an if chain
   always_comb begin
      cmd_next = cmd_reg;
      mode_sel_next = mode_sel_reg;
      mode_act_next = mode_act_reg;
      sw_opt_next = sw_opt_reg;
      estop_next = estop_reg;
      decel_next = decel_reg;
      target_next = target_reg;
      fly_stat_next = fly_stat_reg;
      if (bus.wr) begin
         if (bus.addr == sesm_pkg::ADDR_CMD) begin
            cmd_next = bus.wdata[15:0];
         end else if (bus.addr == sesm_pkg::ADDR_MODE_SEL) begin
            if (mode_ok) begin
               mode_sel_next = bus.wdata[7:0];
               mode_act_next = bus.wdata[7:0];
            end
            // refused write keeps both values as they were
         end else if (bus.addr == sesm_pkg::ADDR_SW_OPT) begin
            sw_opt_next = bus.wdata[1:0];
         end else if (bus.addr == sesm_pkg::ADDR_ESTOP_CFG) begin
            estop_next = bus.wdata[1:0];
         end else if (bus.addr == sesm_pkg::ADDR_DECEL) begin
            decel_next = bus.wdata;
         end else if (bus.addr == sesm_pkg::ADDR_TARGET) begin
            target_next = bus.wdata;
         end else if (bus.addr == sesm_pkg::ADDR_FLY_CMD) begin
            if (fly_ok) begin
               mode_sel_next = bus.wdata[7:0];
               mode_act_next = bus.wdata[7:0];
               fly_stat_next = sesm_pkg::FLY_DONE;
            end else begin
               fly_stat_next = sesm_pkg::FLY_REFUSED;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         cmd_reg <= 16'h0000;
         mode_sel_reg <= sesm_pkg::MODE_RESET;
         mode_act_reg <= sesm_pkg::MODE_RESET;
         sw_opt_reg <= 2'h0;
         estop_reg <= sesm_pkg::ESTOP_PROFILE;
         decel_reg <= sesm_pkg::DECEL_RESET;
         target_reg <= 32'h0000_0000;
         fly_stat_reg <= sesm_pkg::FLY_IDLE;
      end else begin
         cmd_reg <= cmd_next;
         mode_sel_reg <= mode_sel_next;
         mode_act_reg <= mode_act_next;
         sw_opt_reg <= sw_opt_next;
         estop_reg <= estop_next;
         decel_reg <= decel_next;
         target_reg <= target_next;
         fly_stat_reg <= fly_stat_next;
      end
   end

   // ---------------------------------------------------------------
   // drive state machine
   // ---------------------------------------------------------------
   logic c_shutdown, c_switch_on, c_enable_op, c_dis_volt, c_qstop;
   logic halt_req;
   logic signed [31:0] spd_next, pos_next, spd_err, spd_err_next;
   logic signed [31:0] pos_err, pos_err_next;
   logic drv_next, mot_next;

   // command word decode, evaluated as a level every cycle
   always_comb begin
      c_dis_volt = !cmd_reg[1];
      c_qstop = cmd_reg[1] && !cmd_reg[2];
      c_shutdown = (cmd_reg[2:0] == 3'h6);
      c_switch_on = (cmd_reg[3:0] == 4'h7);
      c_enable_op = (cmd_reg[3:0] == 4'hf);
      halt_req = cmd_reg[sesm_pkg::CW_HALT];
   end

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         sesm_pkg::ST_SW_ON_DISABLED: begin
            if (c_shutdown) begin
               st_next = sesm_pkg::ST_READY;
            end
         end
         sesm_pkg::ST_READY: begin
            if (c_dis_volt || c_qstop) begin
               st_next = sesm_pkg::ST_SW_ON_DISABLED;
            end else if (c_switch_on && en_sync_reg) begin
               st_next = sesm_pkg::ST_SWITCHED_ON;
            end
         end
         sesm_pkg::ST_SWITCHED_ON: begin
            if (c_dis_volt || c_qstop) begin
               st_next = sesm_pkg::ST_SW_ON_DISABLED;
            end else if (c_shutdown) begin
               st_next = sesm_pkg::ST_READY;
            end else if (c_enable_op && en_sync_reg) begin
               st_next = sesm_pkg::ST_OP_ENABLE;
            end
         end
         sesm_pkg::ST_OP_ENABLE: begin
            if (c_dis_volt) begin
               st_next = sesm_pkg::ST_SW_ON_DISABLED;
            end else if (c_qstop) begin
               st_next = sesm_pkg::ST_QUICK_STOP;
            end else if (c_shutdown) begin
               st_next = sesm_pkg::ST_READY;
            end else if (c_switch_on) begin
               st_next = sesm_pkg::ST_SWITCHED_ON;
            end
         end
         sesm_pkg::ST_QUICK_STOP: begin
            if (c_dis_volt || demanded_speed == 32'sd0) begin
               st_next = sesm_pkg::ST_SW_ON_DISABLED;
            end
         end
         default: st_next = sesm_pkg::ST_SW_ON_DISABLED;
      endcase
      // losing the enable input drops any enabled state at once
      if (!en_sync_reg && st_next != sesm_pkg::ST_READY) begin
         st_next = sesm_pkg::ST_SW_ON_DISABLED;
      end
   end

   // ---------------------------------------------------------------
   // set-point generation and stop ramps
   // ---------------------------------------------------------------
   function automatic logic signed [31:0] ramp(
      input logic signed [31:0] v,
      input logic [31:0] rate
   );
      logic signed [31:0] r;
      r = $signed(rate);
      if (v > r) begin
         ramp = v - r;
      end else if (v < -r) begin
         ramp = v + r;
      end else begin
         ramp = 32'sd0;
      end
   endfunction

   always_comb begin
      spd_next = demanded_speed;
      spd_err_next = demanded_speed - measured_velocity;
      if (st_reg == sesm_pkg::ST_OP_ENABLE &&
          st_next == sesm_pkg::ST_QUICK_STOP) begin
         // start from measured speed and clear the error
         spd_next = measured_velocity;
         spd_err_next = 32'sd0;
      end else if (st_reg == sesm_pkg::ST_QUICK_STOP) begin
         // config 0 uses the profile rate; other values brake at once,
         // and leaving quick stop for disabled drops the speed at once
         if (st_next != sesm_pkg::ST_QUICK_STOP) begin
            spd_next = 32'sd0;
         end else if (estop_reg == sesm_pkg::ESTOP_PROFILE) begin
            spd_next = ramp(demanded_speed, decel_reg);
         end else begin
            spd_next = 32'sd0;
         end
      end else if (st_reg == sesm_pkg::ST_OP_ENABLE &&
                   st_next != sesm_pkg::ST_OP_ENABLE) begin
         spd_next = 32'sd0;
      end else if (st_reg == sesm_pkg::ST_OP_ENABLE && halt_req) begin
         // ramp from demanded speed; errors keep tracking
         spd_next = ramp(demanded_speed, decel_reg);
      end else if (st_reg == sesm_pkg::ST_OP_ENABLE) begin
         spd_next = target_reg;
      end else begin
         spd_next = 32'sd0;
      end
      pos_next = demanded_position + spd_next;
      pos_err_next = pos_next - measured_position;
   end

   // enables are registered outputs taken from the next state
   always_comb begin
      drv_next = en_sync_reg &&
                 (st_next == sesm_pkg::ST_OP_ENABLE ||
                  st_next == sesm_pkg::ST_QUICK_STOP ||
                  (st_next == sesm_pkg::ST_SWITCHED_ON &&
                   sw_opt_reg == sesm_pkg::SW_OPT_ONE));
      mot_next = en_sync_reg &&
                 (st_next == sesm_pkg::ST_OP_ENABLE);
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         st_reg <= sesm_pkg::ST_SW_ON_DISABLED;
         demanded_speed <= 32'sd0;
         demanded_position <= 32'sd0;
         spd_err <= 32'sd0;
         pos_err <= 32'sd0;
         drive_enable <= 1'b0;
         motion_enable <= 1'b0;
      end else begin
         st_reg <= st_next;
         demanded_speed <= spd_next;
         demanded_position <= pos_next;
         spd_err <= spd_err_next;
         pos_err <= pos_err_next;
         drive_enable <= drv_next;
         motion_enable <= mot_next;
      end
   end

   // ---------------------------------------------------------------
   // status word and read port
   // ---------------------------------------------------------------
   logic [15:0] status;
   logic [31:0] rdata_next;

   always_comb begin
      status = 16'h0000;
      status[sesm_pkg::SW_DISABLED] = (st_reg == sesm_pkg::ST_SW_ON_DISABLED);
      status[sesm_pkg::SW_READY] = (st_reg != sesm_pkg::ST_SW_ON_DISABLED);
      status[sesm_pkg::SW_ON] = (st_reg == sesm_pkg::ST_SWITCHED_ON) ||
                                (st_reg == sesm_pkg::ST_OP_ENABLE) ||
                                (st_reg == sesm_pkg::ST_QUICK_STOP);
      status[sesm_pkg::SW_OP_EN] = (st_reg == sesm_pkg::ST_OP_ENABLE) ||
                                   (st_reg == sesm_pkg::ST_QUICK_STOP);
      status[sesm_pkg::SW_QS_N] = (st_reg != sesm_pkg::ST_QUICK_STOP);
      status[sesm_pkg::SW_HALT_DONE] = halt_req && (demanded_speed == 32'sd0);
   end

   // unmapped addresses and write-only words read as zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (bus.rd) begin
         if (bus.addr == sesm_pkg::ADDR_CMD) begin
            rdata_next = {16'h0000, cmd_reg};
         end else if (bus.addr == sesm_pkg::ADDR_STATUS) begin
            rdata_next = {16'h0000, status};
         end else if (bus.addr == sesm_pkg::ADDR_MODE_SEL) begin
            rdata_next = {{24{mode_sel_reg[7]}}, mode_sel_reg};
         end else if (bus.addr == sesm_pkg::ADDR_MODE_ACT) begin
            rdata_next = {{24{mode_act_reg[7]}}, mode_act_reg};
         end else if (bus.addr == sesm_pkg::ADDR_SW_OPT) begin
            rdata_next = {30'h0000_0000, sw_opt_reg};
         end else if (bus.addr == sesm_pkg::ADDR_ESTOP_CFG) begin
            rdata_next = {30'h0000_0000, estop_reg};
         end else if (bus.addr == sesm_pkg::ADDR_DECEL) begin
            rdata_next = decel_reg;
         end else if (bus.addr == sesm_pkg::ADDR_TARGET) begin
            rdata_next = target_reg;
         end else if (bus.addr == sesm_pkg::ADDR_DEM_SPEED) begin
            rdata_next = demanded_speed;
         end else if (bus.addr == sesm_pkg::ADDR_DEM_POS) begin
            rdata_next = demanded_position;
         end else if (bus.addr == sesm_pkg::ADDR_SPD_ERR) begin
            rdata_next = spd_err;
         end else if (bus.addr == sesm_pkg::ADDR_POS_ERR) begin
            rdata_next = pos_err;
         end else if (bus.addr == sesm_pkg::ADDR_FLY_STAT) begin
            rdata_next = {30'h0000_0000, fly_stat_reg};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rdata_next;
      end
   end

endmodule

// >>> sesm_pkg.sv
// Function
// - drive counts as enabled in operation-enable, quick stop, or switched-on when option is 1
// - motor may move only in operation-enable; master requests that state
// - enabled condition is refused unless the enable input level is 1
// - with option 0, entering switched-on disables the drive
// - entering switch-on-disabled disables drive and motor motion
// - with option 1, switched-on stops motion only; drive stays enabled
// - disable request while moving forces demanded speed to zero at once
// - halt ramps down at profile decel from demanded values, errors kept
// - quick stop ramps per emergency config from measured speed, clears error
// - stop commands act only in operation-enable, in any mode
// - mode-select write requests change; readback shows mode in force
// - in operation-enable a mode-select change needs command bit 4 at 0
// - in operation-enable both on-the-fly and mode-select changes allowed
// - on-the-fly targets: 1, 6, -126, -113
// - modes 7, 8, 9 and 10 are real-time modes
package sesm_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses, one 32-bit word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MODE_SEL = 8'h08;
   localparam logic [7:0] ADDR_MODE_ACT = 8'h0c;
   localparam logic [7:0] ADDR_SW_OPT = 8'h10;
   localparam logic [7:0] ADDR_ESTOP_CFG = 8'h14;
   localparam logic [7:0] ADDR_DECEL = 8'h18;
   localparam logic [7:0] ADDR_TARGET = 8'h1c;
   localparam logic [7:0] ADDR_DEM_SPEED = 8'h20;
   localparam logic [7:0] ADDR_DEM_POS = 8'h24;
   localparam logic [7:0] ADDR_SPD_ERR = 8'h28;
   localparam logic [7:0] ADDR_POS_ERR = 8'h2c;
   localparam logic [7:0] ADDR_FLY_CMD = 8'h30;
   localparam logic [7:0] ADDR_FLY_STAT = 8'h34;

   // ---------------------------------------------------------------
   // command and status word fields
   // ---------------------------------------------------------------
   localparam int CW_NEW_SETPOINT = 4;
   localparam int CW_HALT = 8;
   localparam int SW_READY = 0;
   localparam int SW_ON = 1;
   localparam int SW_OP_EN = 2;
   localparam int SW_QS_N = 5;
   localparam int SW_DISABLED = 6;
   localparam int SW_HALT_DONE = 10;

   // ---------------------------------------------------------------
   // mode codes, options, reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] MODE_PROF_POS = 8'h01;
   localparam logic [7:0] MODE_HOMING = 8'h06;
   localparam logic [7:0] MODE_GEAR = 8'h82;
   localparam logic [7:0] MODE_PROF_VEL_C = 8'h8f;
   localparam logic [7:0] MODE_RT_LO = 8'h07;
   localparam logic [7:0] MODE_RT_HI = 8'h0a;
   localparam logic [7:0] MODE_RESET = 8'h01;
   localparam logic [1:0] SW_OPT_ONE = 2'h1;
   localparam logic [1:0] ESTOP_PROFILE = 2'h0;
   localparam logic [31:0] DECEL_RESET = 32'h0000_0010;
   localparam logic [1:0] FLY_IDLE = 2'h0;
   localparam logic [1:0] FLY_DONE = 2'h1;
   localparam logic [1:0] FLY_REFUSED = 2'h2;

   typedef enum {
      ST_SW_ON_DISABLED, ST_READY, ST_SWITCHED_ON, ST_OP_ENABLE, ST_QUICK_STOP
   } sesm_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } sesm_bus_t;

endpackage

// >>> sesm_checker.sv
module sesm_checker (
   input wire logic clock, // system clock
   input wire logic resetn, // synchronous reset, active low
   input wire sesm_pkg::sesm_bus_t bus, // register port request
   input wire logic enable_input_level, // enable pin
   input wire logic signed [31:0] measured_velocity, // feedback speed
   input wire logic signed [31:0] measured_position, // feedback position
   input wire logic [31:0] rdata, // read data
   input wire logic drive_enable, // power stage enabled
   input wire logic motion_enable, // motor may move
   input wire logic signed [31:0] demanded_speed, // speed set-point
   input wire logic signed [31:0] demanded_position // position set-point
);
   logic [15:0] cmd_reg, cmd_next;
   logic signed [31:0] tgt_reg, tgt_next, decel_reg, decel_next;
   logic [1:0] estop_reg, estop_next;

   // ---------------------------------------------------------------
   // shadow of the command, target, decel and stop-config registers, seen from the bus alone
   // ---------------------------------------------------------------
   always_comb begin
      cmd_next = cmd_reg;
      tgt_next = tgt_reg;
      decel_next = decel_reg;
      estop_next = estop_reg;
      if (bus.wr) begin
         case (bus.addr)
            sesm_pkg::ADDR_CMD: cmd_next = bus.wdata[15:0];
            sesm_pkg::ADDR_TARGET: tgt_next = bus.wdata;
            sesm_pkg::ADDR_DECEL: decel_next = bus.wdata;
            sesm_pkg::ADDR_ESTOP_CFG: estop_next = bus.wdata[1:0];
            default: ;
         endcase
      end
   end

   // shadow registers only; the design itself is never peeked into
   always_ff @(posedge clock) begin
      if (!resetn) begin
         cmd_reg <= 16'h0;
         tgt_reg <= 32'sh0;
         decel_reg <= sesm_pkg::DECEL_RESET;
         estop_reg <= 2'h0;
      end else begin
         cmd_reg <= cmd_next;
         tgt_reg <= tgt_next;
         decel_reg <= decel_next;
         estop_reg <= estop_next;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   a_read_idle_zero: assert property (
      !$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data outside its cycle");
   a_motion_needs_drive: assert property (
      motion_enable |-> drive_enable)
      else $error("motion without drive");
   // pin to enable output is three edges: two sync stages and the output
   a_rise_needs_pin: assert property (
      $rose(drive_enable) |-> $past(enable_input_level, 3))
      else $error("drive enabled with pin low");
   a_pin_low_off: assert property (
      !enable_input_level [*5] |-> !drive_enable && !motion_enable)
      else $error("pin low did not disable");
   a_off_speed_zero: assert property (
      !drive_enable |-> demanded_speed == 32'sh0)
      else $error("speed nonzero while disabled");
   a_pos_integrates: assert property (
      demanded_position == $past(demanded_position) + demanded_speed)
      else $error("position set-point does not follow speed");
   a_follow_target: assert property (
      motion_enable && $past(motion_enable) && !$past(cmd_reg[8])
      && $stable(tgt_reg) |-> demanded_speed == tgt_reg)
      else $error("speed does not follow target");
   a_halt_ramp: assert property (
      $past(cmd_reg[8]) && motion_enable && $past(motion_enable)
      && $past(demanded_speed) >= 0 |-> demanded_speed ==
      (($past(demanded_speed) > $past(decel_reg)) ?
      $past(demanded_speed) - $past(decel_reg) : 32'sh0))
      else $error("halt ramp wrong");
   a_qstop_load: assert property (
      $fell(motion_enable) && drive_enable && $past(cmd_reg[2:1]) == 2'b01
      && $stable(measured_velocity) |-> demanded_speed == measured_velocity)
      else $error("quick stop did not start from measured speed");
   a_qstop_fast: assert property (
      $fell(motion_enable) && drive_enable && $past(cmd_reg[2:1]) == 2'b01
      && estop_reg != 2'h0 |=> demanded_speed == 32'sh0)
      else $error("immediate quick stop not taken");
endmodule

bind sesm_top sesm_checker u_sesm_checker (.clock(clock), .resetn(resetn),
   .bus(bus), .enable_input_level(enable_input_level),
   .measured_velocity(measured_velocity),
   .measured_position(measured_position), .rdata(rdata),
   .drive_enable(drive_enable), .motion_enable(motion_enable),
   .demanded_speed(demanded_speed), .demanded_position(demanded_position));

// >>> sesm_master.sv
module sesm_master (
   input wire logic clock, // system clock
   input wire logic [31:0] rdata, // read data from the block
   output sesm_pkg::sesm_bus_t bus // request toward the block
);
   timeunit 1ns;
   timeprecision 1ps;

   initial bus = '{addr: 8'h00, wdata: 32'h0, wr: 1'b0, rd: 1'b0};

   // idle shows inverted stale values so nothing relies on leftovers
   task automatic idle();
      bus <= '{addr: ~bus.addr, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b0};
   endtask

   // commands reach the drive only through the command word
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      idle();
   endtask

   // status is observed by reading; data stands one cycle only
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      bus <= '{addr: a, wdata: bus.wdata, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      idle();
      #1 v = rdata;
   endtask
endmodule

// >>> tb_servo_enable_stop_mode_control.sv
module tb_servo_enable_stop_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, resetn, en_pin, drive_en, motion_en;
   sesm_pkg::sesm_bus_t bus;
   logic signed [31:0] meas_vel, dem_spd, dem_pos;
   logic [31:0] rdata, seed, d, tgt;
   logic [7:0] codes [4];
   int mismatches, samples_checked, i;

   // ---------------------------------------------------------------
   // clock, partner and design
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   sesm_master u_sesm_master (.clock(clock), .rdata(rdata), .bus(bus));
   sesm_top u_sesm_top (.clock(clock), .resetn(resetn), .bus(bus),
      .enable_input_level(en_pin), .measured_velocity(meas_vel),
      .measured_position(32'sh0), .rdata(rdata), .drive_enable(drive_en),
      .motion_enable(motion_en), .demanded_speed(dem_spd),
      .demanded_position(dem_pos));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] v);
      u_sesm_master.wr(a, v);
   endtask
   // masked read compare; narrow fields sit in the low bits
   task automatic rc(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      u_sesm_master.rd(a, d);
      chk(d & m, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic go_op();
      w(sesm_pkg::ADDR_CMD, 32'h6);
      w(sesm_pkg::ADDR_CMD, 32'h7);
      w(sesm_pkg::ADDR_CMD, 32'hf);
      settle(2);
   endtask
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      seed = 32'hd4b09120;
      codes = '{sesm_pkg::MODE_PROF_POS, sesm_pkg::MODE_HOMING,
         sesm_pkg::MODE_GEAR, sesm_pkg::MODE_PROF_VEL_C};
      resetn = 1'b0;
      en_pin = 1'b0;
      meas_vel = 32'sh0;
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      settle(3);
      chk({drive_en, motion_en}, 32'h0);
      rc(sesm_pkg::ADDR_MODE_ACT, 32'hff, 32'h1);
      rc(sesm_pkg::ADDR_DECEL, 32'hffffffff, 32'h10);
      rc(8'h3c, 32'hffffffff, 32'h0);
      rc(sesm_pkg::ADDR_STATUS, 32'h67, 32'h60);
      go_op();
      chk({drive_en, motion_en}, 32'h0);
      $display("reset and pin test done");
      en_pin <= 1'b1;
      settle(3);
      go_op();
      chk({drive_en, motion_en}, 32'h3);
      rc(sesm_pkg::ADDR_STATUS, 32'h67, 32'h27);
      for (i = 0; i < 4; i++) begin
         tgt = xs() & 32'h0fff;
         w(sesm_pkg::ADDR_TARGET, tgt);
         settle(2);
         chk(dem_spd, tgt);
      end
      w(sesm_pkg::ADDR_CMD, 32'h6);
      settle(1);
      chk(dem_spd, 32'h0);
      chk({drive_en, motion_en}, 32'h0);
      w(sesm_pkg::ADDR_SW_OPT, 32'h1);
      go_op();
      w(sesm_pkg::ADDR_CMD, 32'h7);
      settle(1);
      chk(dem_spd, 32'h0);
      chk({drive_en, motion_en}, 32'h2);
      w(sesm_pkg::ADDR_CMD, 32'hf);
      w(sesm_pkg::ADDR_SW_OPT, 32'h0);
      w(sesm_pkg::ADDR_CMD, 32'h7);
      settle(1);
      chk({drive_en, motion_en}, 32'h0);
      $display("enable test done");
      // speed is zero before any mode-select change
      w(sesm_pkg::ADDR_TARGET, 32'h0);
      w(sesm_pkg::ADDR_CMD, 32'h0);
      w(sesm_pkg::ADDR_MODE_SEL, 32'h3);
      rc(sesm_pkg::ADDR_MODE_ACT, 32'hff, 32'h3);
      rc(sesm_pkg::ADDR_STATUS, 32'h47, 32'h40);
      go_op();
      w(sesm_pkg::ADDR_CMD, 32'h1f);
      w(sesm_pkg::ADDR_MODE_SEL, 32'h6);
      rc(sesm_pkg::ADDR_MODE_ACT, 32'hff, 32'h3);
      rc(sesm_pkg::ADDR_MODE_SEL, 32'hff, 32'h3);
      w(sesm_pkg::ADDR_CMD, 32'hf);
      w(sesm_pkg::ADDR_MODE_SEL, 32'h6);
      rc(sesm_pkg::ADDR_MODE_ACT, 32'hff, 32'h6);
      foreach (codes[k]) begin
         w(sesm_pkg::ADDR_FLY_CMD, {24'h0, codes[k]});
         rc(sesm_pkg::ADDR_FLY_STAT, 32'h3, 32'h1);
         rc(sesm_pkg::ADDR_MODE_ACT, 32'hff, 32'(codes[k]));
      end
      w(sesm_pkg::ADDR_FLY_CMD, 32'h5);
      rc(sesm_pkg::ADDR_FLY_STAT, 32'h3, 32'h2);
      w(sesm_pkg::ADDR_MODE_SEL, 32'h8);
      w(sesm_pkg::ADDR_FLY_CMD, 32'h1);
      rc(sesm_pkg::ADDR_FLY_STAT, 32'h3, 32'h2);
      rc(sesm_pkg::ADDR_MODE_ACT, 32'hff, 32'h8);
      $display("mode test done");
      // stops are issued while the real-time mode stays active
      w(sesm_pkg::ADDR_TARGET, 32'h100);
      w(sesm_pkg::ADDR_CMD, 32'h10f);
      for (i = 0; i < 40 && dem_spd !== 32'sh0; i++) settle(1);
      chk(dem_spd, 32'h0);
      rc(sesm_pkg::ADDR_STATUS, 32'h404, 32'h404);
      w(sesm_pkg::ADDR_CMD, 32'hf);
      meas_vel <= 32'sh80;
      w(sesm_pkg::ADDR_CMD, 32'hb);
      settle(1);
      chk(dem_spd, 32'h80);
      for (i = 0; i < 40 && drive_en !== 1'b0; i++) settle(1);
      rc(sesm_pkg::ADDR_STATUS, 32'h47, 32'h40);
      w(sesm_pkg::ADDR_ESTOP_CFG, 32'h1);
      go_op();
      // stop before disabling, as a careful master does
      w(sesm_pkg::ADDR_CMD, 32'hb);
      // read lands on the entry cycle: error was 0x80, must now be clear
      rc(sesm_pkg::ADDR_SPD_ERR, 32'hffffffff, 32'h0);
      chk(dem_spd, 32'h0);
      w(sesm_pkg::ADDR_CMD, 32'h0);
      $display("stop test done");
      report_and_stop();
   end

   // watchdog, far beyond the few hundred cycles the tests take
   initial begin
      #(20000 * 50);
      mismatches++;
      report_and_stop();
   end
endmodule
